// file: reader_cmd_consts.svh
// Constants of the reader command sequencer: command codes, timing counts and reset values.
`ifndef READER_CMD_CONSTS_SVH
`define READER_CMD_CONSTS_SVH
`define CMD_IDLE 6'h00
`define CMD_AUTH_ONE 6'h0C
`define CMD_AUTH_TWO 6'h14
`define CMD_CRC 6'h12
`define CMD_INIT 6'h3F
`define CLK_PERIOD_NS 8
`define RESET_PHASE_NS 80
`define RESET_PHASE_CYCLES ((`RESET_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_LOAD_WORDS 4
`define AUTH_ONE_ARG_BYTES 6
`define CRC_PRESET 16'h6363
`define CRC_POLY 16'h8408
`define PAGE0_ADDR 6'h00
`endif

// file: reader_cmd_pkg.sv
// Types shared by the reader command sequencer.
`default_nettype none
package reader_cmd_pkg;
    typedef enum logic [5:0] {
        ST_RESET = 6'b000001,
        ST_LOAD = 6'b000010,
        ST_IDLE = 6'b000100,
        ST_AUTH_ONE = 6'b001000,
        ST_AUTH_TWO = 6'b010000,
        ST_CRC = 6'b100000
    } seq_state_t;
endpackage
`default_nettype wire

// file: crc_engine.sv
// Byte-serial checksum engine used by the checksum command.
`timescale 1ns/1ns
`default_nettype none
`include "reader_cmd_consts.svh"
module crc_engine (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clear_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    output logic [15:0] crc_o
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            crc_o <= `CRC_PRESET;
        else if (clear_i)
            crc_o <= `CRC_PRESET;
        else if (byte_valid_i)
            crc_o <= crc_step(crc_o, byte_i);
    end
endmodule
`default_nettype wire

// file: reader_command_sequencer.sv
// Command sequencer: start-up, idle, authentication phases and checksum command.
`timescale 1ns/1ns
`default_nettype none
`include "reader_cmd_consts.svh"
module reader_command_sequencer #(
    parameter int LOAD_WORDS = `INIT_LOAD_WORDS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic digital_supply_pin_i,
    input wire logic analog_supply_pin_i,
    input wire logic reset_powerdown_pin_i,
    input wire logic cmd_write_i,
    input wire logic [5:0] cmd_data_i,
    input wire logic host_read_i,
    input wire logic [5:0] host_read_addr_i,
    output logic read_allowed_o,
    output logic [5:0] command_o,
    input wire logic fifo_empty_i,
    input wire logic [7:0] fifo_data_i,
    output logic fifo_pop_o,
    output logic auth_phase_one_cmd_o,
    output logic auth_phase_two_cmd_o,
    output logic [47:0] auth_args_o,
    input wire logic auth_done_i,
    output logic cfg_read_o,
    output logic [7:0] cfg_addr_o,
    input wire logic [7:0] cfg_data_i,
    output logic [7:0] cfg_word_o [LOAD_WORDS],
    output logic [7:0] checksum_result_low_o,
    output logic [7:0] checksum_result_high_o,
    output logic wait_state_irq_flag_o,
    input wire logic irq_clear_i
);
    localparam int RST_CYC = (`RESET_PHASE_CYCLES < 1) ? 1 : `RESET_PHASE_CYCLES;

    reader_cmd_pkg::seq_state_t state;
    reader_cmd_pkg::seq_state_t next_state;
    logic [7:0] count;
    logic [2:0] arg_count;
    logic sup_d;
    logic sup_a;
    logic pin_q;
    logic power_event;
    logic host_idle;
    logic self_done;
    logic crc_clear;
    logic crc_feed;
    logic [15:0] crc_value;

    // A supply rising or the reset pin falling restarts the whole start-up sequence.
    assign power_event = (digital_supply_pin_i & ~sup_d) | (analog_supply_pin_i & ~sup_a)
        | (pin_q & ~reset_powerdown_pin_i);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // Supplies count as good at reset, so releasing reset raises no false power event.
            sup_d <= 1'b1;
            sup_a <= 1'b1;
            pin_q <= 1'b0;
        end
        else
        begin
            sup_d <= digital_supply_pin_i;
            sup_a <= analog_supply_pin_i;
            pin_q <= reset_powerdown_pin_i;
        end
    end

    // Host writes are ignored outright in the start-up states.
    assign host_idle = cmd_write_i && cmd_data_i == `CMD_IDLE
        && state != reader_cmd_pkg::ST_RESET && state != reader_cmd_pkg::ST_LOAD;

    assign crc_feed = state == reader_cmd_pkg::ST_CRC && !fifo_empty_i && !host_idle;
    assign crc_clear = state == reader_cmd_pkg::ST_IDLE && cmd_write_i && cmd_data_i == `CMD_CRC;

    always_comb
    begin
        next_state = state;
        self_done = 1'b0;
        case (state)
            reader_cmd_pkg::ST_RESET:
                if (count == 8'(RST_CYC - 1))
                    next_state = reader_cmd_pkg::ST_LOAD;
            reader_cmd_pkg::ST_LOAD:
                if (count == 8'(LOAD_WORDS))
                    next_state = reader_cmd_pkg::ST_IDLE;
            reader_cmd_pkg::ST_IDLE:
                if (cmd_write_i)
                begin
                    // The start-up code from the host is treated as a no-op.
                    case (cmd_data_i)
                        `CMD_AUTH_ONE: next_state = reader_cmd_pkg::ST_AUTH_ONE;
                        `CMD_AUTH_TWO: next_state = reader_cmd_pkg::ST_AUTH_TWO;
                        `CMD_CRC: next_state = reader_cmd_pkg::ST_CRC;
                        default: next_state = reader_cmd_pkg::ST_IDLE;
                    endcase
                end
            reader_cmd_pkg::ST_AUTH_ONE, reader_cmd_pkg::ST_AUTH_TWO:
                if (host_idle)
                    next_state = reader_cmd_pkg::ST_IDLE;
                else if (auth_done_i && arg_count == 3'(`AUTH_ONE_ARG_BYTES))
                begin
                    next_state = reader_cmd_pkg::ST_IDLE;
                    self_done = 1'b1;
                end
            reader_cmd_pkg::ST_CRC:
                if (host_idle)
                    next_state = reader_cmd_pkg::ST_IDLE;
                else if (fifo_empty_i)
                begin
                    next_state = reader_cmd_pkg::ST_IDLE;
                    self_done = 1'b1;
                end
            default:
                next_state = reader_cmd_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state <= reader_cmd_pkg::ST_RESET;
        else if (power_event)
            state <= reader_cmd_pkg::ST_RESET;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            count <= 8'h00;
        else if (power_event || state != next_state)
            count <= 8'h00;
        else if (state == reader_cmd_pkg::ST_RESET || state == reader_cmd_pkg::ST_LOAD)
            count <= count + 8'h01;
    end

    // Argument bytes are taken from the FIFO only by phase one; aborts pop nothing more.
    assign fifo_pop_o = !fifo_empty_i && !host_idle && (crc_feed
        || (state == reader_cmd_pkg::ST_AUTH_ONE
        && arg_count != 3'(`AUTH_ONE_ARG_BYTES)));

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            arg_count <= 3'h0;
            auth_args_o <= 48'h0;
        end
        else if (state == reader_cmd_pkg::ST_IDLE)
            // Phase two has no arguments, so it starts with its count already full.
            arg_count <= (cmd_data_i == `CMD_AUTH_TWO) ? 3'(`AUTH_ONE_ARG_BYTES) : 3'h0;
        else if (state == reader_cmd_pkg::ST_AUTH_ONE && fifo_pop_o)
        begin
            arg_count <= arg_count + 3'h1;
            auth_args_o <= {fifo_data_i, auth_args_o[47:8]};
        end
    end

    assign auth_phase_one_cmd_o = state == reader_cmd_pkg::ST_AUTH_ONE
        && arg_count == 3'(`AUTH_ONE_ARG_BYTES);
    assign auth_phase_two_cmd_o = state == reader_cmd_pkg::ST_AUTH_TWO;

    assign cfg_read_o = state == reader_cmd_pkg::ST_LOAD && count < 8'(LOAD_WORDS);
    assign cfg_addr_o = count;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < LOAD_WORDS; i++)
                cfg_word_o[i] <= 8'h00;
        end
        else if (cfg_read_o)
            cfg_word_o[count[$clog2(LOAD_WORDS)-1:0]] <= cfg_data_i;
    end

    crc_engine u_crc (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_i(crc_clear),
        .byte_valid_i(crc_feed),
        .byte_i(fifo_data_i),
        .crc_o(crc_value)
    );

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            checksum_result_low_o <= 8'h00;
            checksum_result_high_o <= 8'h00;
        end
        else if (state == reader_cmd_pkg::ST_CRC && self_done)
        begin
            checksum_result_low_o <= crc_value[7:0];
            checksum_result_high_o <= crc_value[15:8];
        end
    end

    // The set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wait_state_irq_flag_o <= 1'b0;
        else if (self_done)
            wait_state_irq_flag_o <= 1'b1;
        else if (irq_clear_i)
            wait_state_irq_flag_o <= 1'b0;
    end

    always_comb
    begin
        case (state)
            reader_cmd_pkg::ST_RESET, reader_cmd_pkg::ST_LOAD: command_o = `CMD_INIT;
            reader_cmd_pkg::ST_AUTH_ONE: command_o = `CMD_AUTH_ONE;
            reader_cmd_pkg::ST_AUTH_TWO: command_o = `CMD_AUTH_TWO;
            reader_cmd_pkg::ST_CRC: command_o = `CMD_CRC;
            default: command_o = `CMD_IDLE;
        endcase
    end

    assign read_allowed_o = host_read_i && (host_read_addr_i == `PAGE0_ADDR
        || (state != reader_cmd_pkg::ST_RESET && state != reader_cmd_pkg::ST_LOAD));

    property p_init_ignores_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == reader_cmd_pkg::ST_LOAD && cmd_write_i && !power_event
        && count != 8'(LOAD_WORDS)) |=> state == reader_cmd_pkg::ST_LOAD;
    endproperty
    a_init_ignores_write: assert property (p_init_ignores_write) else $error("init cut");

    property p_init_to_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == reader_cmd_pkg::ST_LOAD && count == 8'(LOAD_WORDS) && !power_event)
        |=> command_o == `CMD_IDLE;
    endproperty
    a_init_to_idle: assert property (p_init_to_idle) else $error("init no idle");

    property p_abort_no_flag;
        @(posedge clk_i) disable iff (!nrst_i)
        (host_idle && state != reader_cmd_pkg::ST_IDLE && !wait_state_irq_flag_o)
        |=> !wait_state_irq_flag_o;
    endproperty
    a_abort_no_flag: assert property (p_abort_no_flag) else $error("abort set flag");

    property p_abort_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (host_idle && !power_event) |=> state == reader_cmd_pkg::ST_IDLE;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("abort ignored");

    property p_done_flag;
        @(posedge clk_i) disable iff (!nrst_i)
        (self_done && !power_event) |=> wait_state_irq_flag_o && command_o == `CMD_IDLE;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done no flag");

    property p_no_host_init;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == reader_cmd_pkg::ST_IDLE && cmd_write_i && cmd_data_i == `CMD_INIT
        && !power_event) |=> state == reader_cmd_pkg::ST_IDLE;
    endproperty
    a_no_host_init: assert property (p_no_host_init) else $error("host init");

    property p_page0_only;
        @(posedge clk_i) disable iff (!nrst_i)
        (read_allowed_o && command_o == `CMD_INIT) |-> host_read_addr_i == `PAGE0_ADDR;
    endproperty
    a_page0_only: assert property (p_page0_only) else $error("read in init");

    property p_power_restart;
        @(posedge clk_i) disable iff (!nrst_i)
        power_event |=> state == reader_cmd_pkg::ST_RESET ##1 command_o == `CMD_INIT;
    endproperty
    a_power_restart: assert property (p_power_restart) else $error("no restart");

    property p_crc_result;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == reader_cmd_pkg::ST_CRC && self_done)
        |=> {checksum_result_high_o, checksum_result_low_o} == $past(crc_value);
    endproperty
    a_crc_result: assert property (p_crc_result) else $error("crc result");

    c_auth_one: cover property (@(posedge clk_i) disable iff (!nrst_i)
        auth_phase_one_cmd_o ##[1:50] self_done);
    c_crc_run: cover property (@(posedge clk_i) disable iff (!nrst_i)
        crc_feed ##[1:50] self_done);
    c_abort: cover property (@(posedge clk_i) disable iff (!nrst_i)
        host_idle && state != reader_cmd_pkg::ST_IDLE);
endmodule
`default_nettype wire

// file: reader_far_side_model.sv
// Far side model: data buffer, configuration store and cipher engine.
`timescale 1ns/1ns
`default_nettype none
module reader_far_side_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fifo_pop_i,
    output logic fifo_empty_o,
    output logic [7:0] fifo_data_o,
    output logic [7:0] level_o,
    input wire logic [7:0] cfg_addr_i,
    output logic [7:0] cfg_data_o,
    input wire logic auth_run_i,
    input wire logic slow_i,
    output logic auth_done_o
);
    logic [7:0] q [$];
    logic [7:0] last;
    logic [7:0] cnt;
    initial
    begin
        last = 8'h00;
        level_o = 8'h00;
        fifo_empty_o = 1'b1;
        fifo_data_o = 8'hFF;
    end
    task automatic push(input logic [7:0] b);
        q.push_back(b);
        level_o = 8'(q.size());
        fifo_empty_o = 1'b0;
        fifo_data_o = q[0];
    endtask
    // An empty buffer shows the inverse of the last byte, so stale data never looks valid.
    always @(posedge clk_i)
    begin
        if (fifo_pop_i && q.size() > 0)
        begin
            last = q.pop_front();
            level_o <= 8'(q.size());
            fifo_empty_o <= (q.size() == 0);
            fifo_data_o <= (q.size() == 0) ? ~last : q[0];
        end
    end
    assign cfg_data_o = cfg_addr_i ^ 8'hA5;
    // The slow mode never finishes, which leaves room for an abort.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt <= 8'h00;
            auth_done_o <= 1'b0;
        end
        else
        begin
            auth_done_o <= auth_run_i && !auth_done_o && !slow_i && cnt == 8'h03;
            cnt <= (auth_run_i && !auth_done_o) ? cnt + 8'h01 : 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: tb_reader_command_sequencer.sv
// Self-checking bench for the reader command sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_reader_command_sequencer;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic dsup = 1'b1;
    logic asup = 1'b1;
    logic rpd = 1'b1;
    logic wr_en = 1'b0;
    logic [5:0] wr_code = 6'h00;
    logic rd = 1'b0;
    logic [5:0] rd_addr = 6'h00;
    logic irq_clr = 1'b0;
    logic slow = 1'b0;
    logic rd_ok, empty, pop, a1, a2, done, flag, cfg_rd;
    logic [5:0] cmd;
    logic [7:0] fdata, level, caddr, cdata, lo, hi;
    logic [47:0] args;
    logic [7:0] cfg [4];
    int err_total = 0;
    int checked = 0;
    always #4 clk_i = ~clk_i;
    reader_command_sequencer #(.LOAD_WORDS(4)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .digital_supply_pin_i(dsup),
        .analog_supply_pin_i(asup), .reset_powerdown_pin_i(rpd), .cmd_write_i(wr_en),
        .cmd_data_i(wr_code), .host_read_i(rd), .host_read_addr_i(rd_addr),
        .read_allowed_o(rd_ok), .command_o(cmd), .fifo_empty_i(empty), .fifo_data_i(fdata),
        .fifo_pop_o(pop), .auth_phase_one_cmd_o(a1), .auth_phase_two_cmd_o(a2),
        .auth_args_o(args), .auth_done_i(done), .cfg_read_o(cfg_rd), .cfg_addr_o(caddr),
        .cfg_data_i(cdata), .cfg_word_o(cfg), .checksum_result_low_o(lo),
        .checksum_result_high_o(hi), .wait_state_irq_flag_o(flag), .irq_clear_i(irq_clr)
    );
    reader_far_side_model u_far (
        .clk_i(clk_i), .nrst_i(nrst_i), .fifo_pop_i(pop), .fifo_empty_o(empty),
        .fifo_data_o(fdata), .level_o(level), .cfg_addr_i(caddr), .cfg_data_o(cdata),
        .auth_run_i(a1 | a2), .slow_i(slow), .auth_done_o(done)
    );
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] code);
        @(negedge clk_i);
        wr_code = code;
        wr_en = 1'b1;
        @(negedge clk_i);
        wr_en = 1'b0;
    endtask
    task automatic clr();
        @(negedge clk_i);
        irq_clr = 1'b1;
        @(negedge clk_i);
        irq_clr = 1'b0;
    endtask
    task automatic wait_idle();
        // The host polls the command register and writes nothing until idle shows.
        for (int n = 0; n < 60 && cmd !== 6'h00; n++) @(negedge clk_i);
    endtask
    task automatic t_power_on_init_cmd();
        check("start code", cmd, 6'h3F);
        check("reset flag", flag, 1'b0);
        check("reset result", {hi, lo}, 16'h0000);
        rd = 1'b1;
        rd_addr = 6'h05;
        #1 check("read blocked", rd_ok, 1'b0);
        @(negedge clk_i);
        rd_addr = 6'h00;
        #1 check("page 0 read", rd_ok, 1'b1);
        wr(6'h00);
        check("start not stopped", cmd, 6'h3F);
        wait_idle();
        check("idle after start", cmd, 6'h00);
        rd_addr = 6'h05;
        #1 check("read after start", rd_ok, 1'b1);
        @(negedge clk_i);
        rd = 1'b0;
        check("config read off", cfg_rd, 1'b0);
        for (int i = 0; i < 4; i++) check("config word", cfg[i], 8'(i) ^ 8'hA5);
        clr();
        $display("test power_on_init_cmd done");
    endtask
    task automatic t_codes();
        wr(6'h3F);
        check("init code refused", cmd, 6'h00);
        wr(6'h1A);
        check("other code", cmd, 6'h00);
        wr(6'h00);
        check("idle code", cmd, 6'h00);
        check("idle no flag", flag, 1'b0);
        $display("test codes done");
    endtask
    task automatic t_crc(input int n);
        logic [15:0] crc;
        logic [7:0] b;
        crc = 16'h6363;
        for (int i = 0; i < n; i++)
        begin
            b = 8'(8'h31 + i * 8'h17);
            u_far.push(b);
            crc = crc ^ {8'h00, b};
            for (int j = 0; j < 8; j++) crc = crc[0] ? (crc >> 1) ^ 16'h8408 : crc >> 1;
        end
        wr(6'h12);
        check("crc running", cmd, 6'h12);
        wait_idle();
        check("crc end", cmd, 6'h00);
        check("crc low", lo, crc[7:0]);
        check("crc high", hi, crc[15:8]);
        check("crc bytes used", level, 8'h00);
        check("crc flag", flag, 1'b1);
        clr();
        check("flag cleared", flag, 1'b0);
        $display("test checksum done");
    endtask
    task automatic t_auth();
        logic [47:0] exp;
        exp = 48'h443322110460;
        for (int i = 0; i < 6; i++) u_far.push(exp[8*i +: 8]);
        wr(6'h0C);
        check("phase one code", cmd, 6'h0C);
        // Six pops take six cycles; the cipher is then started and finishes later.
        repeat (6) @(negedge clk_i);
        check("phase one run", a1, 1'b1);
        wait_idle();
        check("phase one args", args, exp);
        check("phase one flag", flag, 1'b1);
        clr();
        u_far.push(8'h5A);
        wr(6'h14);
        check("phase two run", a2, 1'b1);
        wait_idle();
        check("phase two flag", flag, 1'b1);
        check("phase two no pop", level, 8'h01);
        clr();
        slow = 1'b1;
        wr(6'h14);
        repeat (3) @(negedge clk_i);
        wr(6'h00);
        check("abort", cmd, 6'h00);
        check("abort flag", flag, 1'b0);
        check("abort buffer", level, 8'h01);
        slow = 1'b0;
        $display("test authentication done");
    endtask
    task automatic t_power();
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk_i);
            {dsup, asup, rpd} = 3'b111 ^ (3'b100 >> k);
            @(negedge clk_i);
            {dsup, asup, rpd} = 3'b111;
            @(negedge clk_i);
            check("power event", cmd, 6'h3F);
            wait_idle();
            check("idle after event", cmd, 6'h00);
        end
        $display("test power events done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        t_power_on_init_cmd();
        t_codes();
        t_crc(0);
        t_crc(3);
        t_auth();
        t_power();
        give_verdict();
    end
    // The whole run needs about 120 cycles; this bound cuts a hang short.
    initial
    begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
